/* rtl/code_prefetch_queue_branch_cache.sv */
// code lookahead queue with branch target store, feeding the execution unit
module code_prefetch_queue_branch_cache
    import fetch_pkg::*;
#(
    parameter int DEPTH   = QUEUE_DEPTH,
    parameter int ENTRIES = STORE_ENTRIES
) (
    // clocking
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // configuration
    input  wire logic                  low_voltage,
    input  wire logic                  btc_we,
    input  wire logic [BTC_W-1:0]      btc_wdata,
    output logic [BTC_W-1:0]           bus_timing_control,
    // execution unit
    input  wire logic                  exec_take,
    input  wire logic [1:0]            exec_len,
    input  wire logic                  exec_branch,
    input  wire logic [ADDR_W-1:0]     exec_target,
    input  wire logic                  data_req,
    output logic                       exec_ready,
    output logic [23:0]                exec_bytes,
    output logic                       mcycle_strobe,
    output logic                       data_done,
    // program memory bus
    output logic                       mem_rd,
    output logic [ADDR_W-1:0]          mem_addr,
    output logic                       mem_data_cycle,
    input  wire logic [7:0]            mem_rdata
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [BTC_W-1:0]  btc_reg;
    logic              low_voltage_meta_reg;
    logic              low_voltage_reg;
    logic [1:0]        phase_reg;
    logic [7:0]        q_reg [DEPTH];
    logic [CW-1:0]     cnt_reg;
    logic [ADDR_W-1:0] fetch_pc_reg;
    bus_state_t        bus_reg;
    logic [3:0]        wait_reg;
    logic              is_data_reg;
    logic              stale_reg;
    logic              exec_ready_reg;
    logic [23:0]       exec_bytes_reg;
    logic              mcycle_reg;
    logic              data_done_reg;
    logic              mem_rd_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic              mem_dc_reg;
    logic              fill_active_reg;

    logic              queue_on;
    logic              cycle_end;
    logic              take_now;
    logic              branch_now;
    logic              hit;
    logic [DEPTH*8-1:0] hit_bytes;
    logic [3:0]        hit_count;
    logic              byte_in;
    logic [3:0]        code_wait;
    logic [3:0]        data_wait;

    assign queue_on   = btc_reg[BTC_QUEUE_EN_BIT];
    assign cycle_end  = (phase_reg == 2'(CLKS_PER_MCYCLE - 1));
    assign take_now   = cycle_end && exec_take && (CW'(exec_len) <= cnt_reg) && !exec_branch;
    assign branch_now = cycle_end && exec_branch;
    assign byte_in    = (bus_reg == BUS_DONE) && !is_data_reg && !stale_reg;
    assign code_wait  = btc_reg[BTC_CODE_WAIT_LSB +: 4];
    assign data_wait  = btc_reg[BTC_SPLIT_BIT] ? btc_reg[BTC_DATA_WAIT_LSB +: 4] : code_wait;

    // strap is a pin not timed to clk, so it passes two flops first; the queue is on by default
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_voltage_meta_reg <= 1'b0;
            low_voltage_reg      <= 1'b0;
            btc_reg              <= BTC_RESET_5V;
        end else if (clk_en) begin
            low_voltage_meta_reg <= low_voltage;
            low_voltage_reg      <= low_voltage_meta_reg;
            if (btc_we) begin
                btc_reg <= btc_wdata;
            end else if (low_voltage_reg && btc_reg == BTC_RESET_5V) begin
                btc_reg <= BTC_RESET_3V3;
            end
        end
    end

    // machine cycle phase counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg  <= 2'd0;
            mcycle_reg <= 1'b0;
        end else if (clk_en) begin
            phase_reg  <= cycle_end ? 2'd0 : phase_reg + 2'd1;
            mcycle_reg <= cycle_end;
        end
    end

    // program memory bus with wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_reg       <= BUS_IDLE;
            wait_reg      <= 4'h0;
            is_data_reg   <= 1'b0;
            stale_reg     <= 1'b0;
            mem_rd_reg    <= 1'b0;
            mem_addr_reg  <= RESET_PC;
            mem_dc_reg    <= 1'b0;
            data_done_reg <= 1'b0;
        end else if (clk_en) begin
            data_done_reg <= 1'b0;
            if (branch_now && bus_reg != BUS_IDLE) begin
                stale_reg <= 1'b1;
            end
            unique case (bus_reg)
                BUS_IDLE: begin
                    stale_reg <= 1'b0;
                    if (data_req) begin
                        bus_reg     <= BUS_WAIT;
                        is_data_reg <= 1'b1;
                        mem_dc_reg  <= 1'b1;
                        mem_rd_reg  <= 1'b1;
                        wait_reg    <= data_wait;
                    // only fetch while room remains; disabled mode asks for a single byte
                    end else if (!branch_now && ((queue_on && cnt_reg < CW'(DEPTH))
                                 || (!queue_on && cnt_reg == '0))) begin
                        bus_reg      <= BUS_WAIT;
                        is_data_reg  <= 1'b0;
                        mem_dc_reg   <= 1'b0;
                        mem_rd_reg   <= 1'b1;
                        mem_addr_reg <= fetch_pc_reg;
                        wait_reg     <= code_wait;
                    end
                end
                BUS_WAIT: begin
                    if (wait_reg == 4'h0) begin
                        bus_reg    <= BUS_DONE;
                        mem_rd_reg <= 1'b0;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                BUS_DONE: begin
                    bus_reg       <= BUS_IDLE;
                    mem_dc_reg    <= 1'b0;
                    data_done_reg <= is_data_reg;
                end
            endcase
        end
    end

    // queue contents, fetch pointer and hand over to execution
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg         <= '0;
            fetch_pc_reg    <= RESET_PC;
            exec_ready_reg  <= 1'b0;
            exec_bytes_reg  <= 24'h000000;
            fill_active_reg <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                q_reg[i] <= 8'h00;
            end
        end else if (clk_en) begin
            exec_ready_reg <= (CW'(exec_len) <= cnt_reg) && (cnt_reg != '0);
            if (branch_now) begin
                if (queue_on && hit) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        q_reg[i] <= hit_bytes[i*8 +: 8];
                    end
                    cnt_reg         <= CW'(hit_count);
                    fetch_pc_reg    <= exec_target + ADDR_W'(hit_count);
                    fill_active_reg <= 1'b0;
                end else begin
                    cnt_reg         <= '0;
                    fetch_pc_reg    <= exec_target;
                    fill_active_reg <= queue_on;
                end
            end else begin
                logic [CW-1:0] base;
                base = cnt_reg;
                if (take_now) begin
                    exec_bytes_reg <= {q_reg[2], q_reg[1], q_reg[0]};
                    for (int i = 0; i < DEPTH; i++) begin
                        q_reg[i] <= (i + int'(exec_len) < DEPTH) ? q_reg[i + int'(exec_len)] : 8'h00;
                    end
                    base = cnt_reg - CW'(exec_len);
                end
                if (byte_in) begin
                    q_reg[base]  <= mem_rdata;
                    fetch_pc_reg <= fetch_pc_reg + 16'h0001;
                    base         = base + 1'b1;
                end
                cnt_reg <= base;
                if (byte_in && fill_active_reg && base == CW'(DEPTH)) begin
                    fill_active_reg <= 1'b0;
                end
            end
        end
    end

    branch_target_store #(
        .ENTRIES (ENTRIES),
        .BYTES   (DEPTH)
    ) u_store (
        .clk        (clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .look_addr  (exec_target),
        .hit        (hit),
        .hit_bytes  (hit_bytes),
        .hit_count  (hit_count),
        .alloc      (branch_now && queue_on && !hit),
        .alloc_addr (exec_target),
        .fill_we    (byte_in && fill_active_reg && queue_on),
        .fill_byte  (mem_rdata)
    );

    assign bus_timing_control = btc_reg;
    assign exec_ready         = exec_ready_reg;
    assign exec_bytes         = exec_bytes_reg;
    assign mcycle_strobe      = mcycle_reg;
    assign data_done          = data_done_reg;
    assign mem_rd             = mem_rd_reg;
    assign mem_addr           = mem_addr_reg;
    assign mem_data_cycle     = mem_dc_reg;
endmodule

/* rtl/fetch_pkg.sv */
// constants and types shared by the code fetch front end
// Operation
// - machine cycle lasts four clocks
// - classic opcodes kept, one third of timing
// - queue fetches ahead whenever bus idle
// - only needed code bytes, no dummy fetches
// - queue holds at most six bytes
// - four entries compared in parallel on branch
// - each entry stores up to six bytes
// - hit moves six bytes into queue at once; here the queue count is the entry's hit_count, up to six
// - queue and store enabled after reset
// - fetches insert bus_timing_control wait states
// - low voltage variant uses five wait states
// - same waits for code and data unless split
// - queued instruction bytes handed over together
// - execution stalls until needed bytes present
package fetch_pkg;
    localparam int          CLKS_PER_MCYCLE = 4;
    localparam int          QUEUE_DEPTH     = 6;
    localparam int          STORE_ENTRIES   = 4;
    localparam int          ADDR_W          = 16;
    localparam logic [3:0]  WAIT_5V         = 4'h4;
    localparam logic [3:0]  WAIT_3V3        = 4'h5;
    localparam logic [ADDR_W-1:0] RESET_PC  = 16'h0000;
    // bus_timing_control layout
    localparam int          BTC_CODE_WAIT_LSB = 0;
    localparam int          BTC_DATA_WAIT_LSB = 4;
    localparam int          BTC_SPLIT_BIT     = 8;
    localparam int          BTC_QUEUE_EN_BIT  = 9;
    localparam int          BTC_W             = 10;
    localparam logic [BTC_W-1:0] BTC_RESET_5V  = 10'h244;
    localparam logic [BTC_W-1:0] BTC_RESET_3V3 = 10'h255;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;
endpackage

/* rtl/branch_target_store.sv */
// four-entry fully associative store of branch destination code bytes
module branch_target_store
    import fetch_pkg::*;
#(
    parameter int ENTRIES = STORE_ENTRIES,
    parameter int BYTES   = QUEUE_DEPTH
) (
    // clocking
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // lookup
    input  wire logic [ADDR_W-1:0]     look_addr,
    output logic                       hit,
    output logic [BYTES*8-1:0]         hit_bytes,
    output logic [3:0]                 hit_count,
    // fill of the newest entry
    input  wire logic                  alloc,
    input  wire logic [ADDR_W-1:0]     alloc_addr,
    input  wire logic                  fill_we,
    input  wire logic [7:0]            fill_byte
);
    localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

    logic [ADDR_W-1:0]  tag_reg   [ENTRIES];
    logic               valid_reg [ENTRIES];
    logic [3:0]         cnt_reg   [ENTRIES];
    logic [7:0]         data_reg  [ENTRIES][BYTES];
    logic [IW-1:0]      oldest_reg;
    logic [IW-1:0]      fill_reg;
    logic [ENTRIES-1:0] match;

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_cmp
            assign match[g] = valid_reg[g] && (tag_reg[g] == look_addr) && (cnt_reg[g] != 4'h0);
        end
    endgenerate

    always_comb begin
        hit       = |match;
        hit_bytes = '0;
        hit_count = 4'h0;
        for (int e = 0; e < ENTRIES; e++) begin
            if (match[e]) begin
                hit_count = cnt_reg[e];
                for (int b = 0; b < BYTES; b++) begin
                    hit_bytes[b*8 +: 8] = data_reg[e][b];
                end
            end
        end
    end

    // round robin on allocation, so the victim is always the oldest entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oldest_reg <= '0;
            fill_reg   <= '0;
            for (int e = 0; e < ENTRIES; e++) begin
                valid_reg[e] <= 1'b0;
                tag_reg[e]   <= '0;
                cnt_reg[e]   <= 4'h0;
                for (int b = 0; b < BYTES; b++) begin
                    data_reg[e][b] <= 8'h00;
                end
            end
        end else if (clk_en) begin
            if (alloc) begin
                valid_reg[oldest_reg] <= 1'b1;
                tag_reg[oldest_reg]   <= alloc_addr;
                cnt_reg[oldest_reg]   <= 4'h0;
                fill_reg              <= oldest_reg;
                oldest_reg            <= (oldest_reg == IW'(ENTRIES - 1)) ? '0 : oldest_reg + 1'b1;
            end else if (fill_we && (cnt_reg[fill_reg] < 4'(BYTES))) begin
                data_reg[fill_reg][cnt_reg[fill_reg][2:0]] <= fill_byte;
                cnt_reg[fill_reg] <= cnt_reg[fill_reg] + 4'h1;
            end
        end
    end
endmodule

/* testbench/code_mem_model.sv */
// program memory model answering fetches from an address pattern
module code_mem_model
    import fetch_pkg::*;
(
    // memory bus
    input  wire logic              clk,
    input  wire logic              mem_rd,
    input  wire logic [ADDR_W-1:0] mem_addr,
    output logic [7:0]             mem_rdata,
    // observation
    output int                     rd_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       hold_reg;
    logic [7:0] last_reg;
    int         count_reg = 0;
    always_ff @(posedge clk) begin
        hold_reg <= mem_rd;
        last_reg <= mem_rdata;
        if (mem_rd && !hold_reg) count_reg <= count_reg + 1;
    end
    assign rd_count = count_reg;
    // byte stands through the done clock, then flips so a late sample cannot pass
    assign mem_rdata = (mem_rd || hold_reg) ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5a) : ~last_reg;
endmodule

/* testbench/code_fetch_sva.sv */
// port checker for the code fetch front end
module code_fetch_checker
    import fetch_pkg::*;
(
    // watched ports
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              low_voltage,
    input wire logic              btc_we,
    input wire logic [BTC_W-1:0]  btc_wdata,
    input wire logic [BTC_W-1:0]  bus_timing_control,
    input wire logic              exec_take,
    input wire logic [1:0]        exec_len,
    input wire logic              exec_branch,
    input wire logic              data_req,
    input wire logic              exec_ready,
    input wire logic [23:0]       exec_bytes,
    input wire logic              mcycle_strobe,
    input wire logic              mem_rd,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_data_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rd_four_waits: assert property ($rose(mem_rd) && !mem_data_cycle
        && $past(bus_timing_control[3:0]) == 4'h4 |-> mem_rd[*5] ##1 !mem_rd)
        else $error("read strobe length wrong at four waits");
    chk_rd_five_waits: assert property ($rose(mem_rd) && !mem_data_cycle
        && $past(bus_timing_control[3:0]) == 4'h5 |-> mem_rd[*6] ##1 !mem_rd)
        else $error("read strobe length wrong at five waits");
    chk_mcycle_period: assert property (mcycle_strobe |=> !mcycle_strobe[*3] ##1 mcycle_strobe)
        else $error("machine cycle strobe not every four clocks");
    chk_btc_write: assert property (btc_we |=> bus_timing_control == $past(btc_wdata))
        else $error("timing control write lost");
    chk_btc_hold: assert property (!btc_we && !low_voltage |=> $stable(bus_timing_control))
        else $error("timing control changed without write");
    chk_addr_hold: assert property (mem_rd && $past(mem_rd) |-> $stable(mem_addr))
        else $error("address moved during read");
    chk_bytes_stand: assert property (mcycle_strobe |=> $stable(exec_bytes)[*3])
        else $error("handed bytes changed inside machine cycle");
    chk_no_fetch_off: assert property (!$past(bus_timing_control[BTC_QUEUE_EN_BIT]) && $rose(mem_rd)
        && !mem_data_cycle && $past(exec_len) == 2'd1 |-> !exec_ready)
        else $error("fetch ahead while queue disabled");
    cover property ($rose(mem_rd));
    cover property (exec_take && exec_ready);
    cover property (btc_we);
endmodule

bind code_prefetch_queue_branch_cache code_fetch_checker i_chk (.clk(clk), .rst(rst), .low_voltage(low_voltage),
    .btc_we(btc_we), .btc_wdata(btc_wdata), .bus_timing_control(bus_timing_control), .exec_take(exec_take),
    .exec_len(exec_len), .exec_branch(exec_branch), .data_req(data_req), .exec_ready(exec_ready),
    .exec_bytes(exec_bytes), .mcycle_strobe(mcycle_strobe), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_data_cycle(mem_data_cycle));

/* testbench/code_prefetch_queue_branch_cache_tb.sv */
// self-checking bench for the code fetch front end
module code_prefetch_queue_branch_cache_tb
    import fetch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, low_voltage = 0, btc_we = 0, exec_take = 0, exec_branch = 0, data_req = 0;
    logic [BTC_W-1:0] btc_wdata = '0, bus_timing_control;
    logic [1:0] exec_len = 2'h1;
    logic [ADDR_W-1:0] exec_target = '0, mem_addr;
    logic exec_ready, mcycle_strobe, data_done, mem_rd, mem_data_cycle;
    logic [23:0] exec_bytes;
    logic [7:0] mem_rdata;
    int rd_count, bad_count = 0, num_checks = 0;
    always #12.5 clk = ~clk;
    code_prefetch_queue_branch_cache i_dut (.clk(clk), .rst(rst), .clk_en(1'b1), .low_voltage(low_voltage),
        .btc_we(btc_we), .btc_wdata(btc_wdata), .bus_timing_control(bus_timing_control), .exec_take(exec_take),
        .exec_len(exec_len), .exec_branch(exec_branch), .exec_target(exec_target), .data_req(data_req),
        .exec_ready(exec_ready), .exec_bytes(exec_bytes), .mcycle_strobe(mcycle_strobe), .data_done(data_done),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data_cycle(mem_data_cycle), .mem_rdata(mem_rdata));
    code_mem_model i_mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .rd_count(rd_count));
    function automatic logic [7:0] f(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hold the request until the next cycle end so the phase-three edge always sees it;
    // at least one edge passes first, so a strobe still high from the last cycle end cannot cut it
    task automatic step(input logic tk, input logic br, input logic [15:0] tgt);
        exec_take = tk;
        exec_branch = br;
        exec_target = tgt;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (mcycle_strobe === 1'b1) break;
        end
        exec_take = 0;
        exec_branch = 0;
        @(negedge clk);
    endtask
    task automatic wait_ready(input logic [1:0] len, output int n);
        exec_len = len;
        repeat (2) @(negedge clk);
        for (n = 0; n < 300 && exec_ready !== 1'b1; n++) @(negedge clk);
        check("exec_ready", 1, exec_ready);
    endtask
    task automatic take(input logic [15:0] a, input logic [1:0] len);
        int n;
        wait_ready(len, n);
        step(1'b1, 1'b0, '0);
        for (int i = 0; i < len; i++) check("exec_bytes", {16'h0, f(a + i)}, {16'h0, exec_bytes[8*i +: 8]});
    endtask
    task automatic t_sequential();
        check("btc reset", BTC_RESET_5V, bus_timing_control);
        take(RESET_PC, 2'd3);
        take(RESET_PC + 3, 2'd2);
        take(RESET_PC + 5, 2'd1);
    endtask
    task automatic t_depth();
        int c;
        step(1'b0, 1'b1, 16'h4000);
        c = rd_count;
        repeat (150) @(negedge clk);
        check("fill reads", 1, (rd_count - c >= 6) && (rd_count - c <= 7));
    endtask
    task automatic t_branch();
        int n;
        step(1'b0, 1'b1, 16'h1234);
        wait_ready(2'd3, n);
        check("miss delay", 1, n > 8);
        repeat (80) @(negedge clk);
        take(16'h1234, 2'd3);
        step(1'b0, 1'b1, 16'h2000);
        take(16'h2000, 2'd1);
        step(1'b0, 1'b1, 16'h1234);
        wait_ready(2'd3, n);
        check("hit delay", 1, n <= 4);
        take(16'h1234, 2'd3);
        take(16'h1237, 2'd3);
    endtask
    task automatic t_disable();
        int c;
        btc_wdata = 10'h044;
        btc_we = 1;
        @(negedge clk);
        btc_we = 0;
        check("btc write", 10'h044, bus_timing_control);
        step(1'b0, 1'b1, 16'h3000);
        c = rd_count;
        repeat (100) @(negedge clk);
        check("on demand reads", 1, rd_count - c <= 2);
        take(16'h3000, 2'd1);
    endtask
    // strobe of a data read lasts its wait count plus one clock
    task automatic t_data(input logic [BTC_W-1:0] cfg, input int exp_rd);
        logic seen;
        int   rd_len;
        seen = 0;
        rd_len = 0;
        btc_wdata = cfg;
        btc_we = 1;
        @(negedge clk);
        btc_we = 0;
        data_req = 1;
        for (int i = 0; i < 60 && data_done !== 1'b1; i++) begin
            @(negedge clk);
            seen = seen | (mem_data_cycle === 1'b1);
            if (mem_rd === 1'b1 && mem_data_cycle === 1'b1) rd_len++;
        end
        data_req = 0;
        check("data cycle", 2'b11, {seen, data_done});
        check("data strobe length", exp_rd, rd_len);
    endtask
    task automatic t_low_voltage();
        low_voltage = 1;
        rst = 1;
        repeat (16) @(negedge clk);
        rst = 0;
        repeat (4) @(negedge clk);
        check("btc low voltage", BTC_RESET_3V3, bus_timing_control);
        take(RESET_PC, 2'd1);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        t_sequential();
        t_depth();
        t_branch();
        t_disable();
        t_data(10'h044, 5);
        t_data(10'h124, 3);
        t_low_voltage();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule
